// >>> console_defines.vh
`ifndef CONSOLE_DEFINES_VH
`define CONSOLE_DEFINES_VH

// ----------------------------------------
// link timing
// ----------------------------------------
`define CON_CLOCK_HZ 250000000
`define CON_BAUD 9600
// clock rate divided by baud rate, rounded down, sized to the bit counters
`define CON_BIT_CYCLES 15'h65b9
`define CON_BOOT_WAIT 2'h3

// ----------------------------------------
// register file
// ----------------------------------------
`define CON_REG_COUNT 29
`define CON_REG_LAST 32'h0000001c
`define CON_REG_LAST_IDX 5'h1c
`define CON_REG_RESET 32'h00000000

// ----------------------------------------
// line buffer
// ----------------------------------------
`define CON_BUF_DEPTH 6'h20
`define CON_CNT_MAX 6'h3f

// ----------------------------------------
// character codes
// ----------------------------------------
`define CON_CHAR_CR 8'h0d
`define CON_CHAR_BS 8'h08
`define CON_CHAR_DEL 8'h7f
`define CON_CHAR_ZERO 8'h30
`define CON_CHAR_NINE 8'h39
`define CON_CHAR_QUERY 8'h3f
`define CON_CHAR_EQUAL 8'h3d
`define CON_CHAR_COLON 8'h3a
`define CON_CHAR_COMMA 8'h2c

// ----------------------------------------
// internal symbol codes and messages
// ----------------------------------------
`define CON_SYM_QUERY 4'ha
`define CON_SYM_EQUAL 4'hb
`define CON_MSG_BANNER 2'h0
`define CON_MSG_CMD_ERR 2'h1
`define CON_MSG_REG_ERR 2'h2

`endif

// >>> serial_tx.v
`timescale 1ns/1ns
`include "console_defines.vh"

module serial_tx #(
  parameter [14:0] BIT_CYCLES = `CON_BIT_CYCLES
) (
  // clock and reset
  input wire i_clock,
  input wire i_rst_b,
  input wire i_clk_en,
  // character handshake
  input wire i_valid,
  input wire [7:0] i_data,
  output wire o_ready,
  // serial line
  output reg o_line
);

  reg busy;
  reg [8:0] shift;
  reg [3:0] bits_left;
  reg [14:0] cycle;

  assign o_ready = ~busy;

  // frame: start low, eight bits lsb first, stop high, idle high
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy <= 1'b0;
      shift <= 9'h1ff;
      bits_left <= 4'h0;
      cycle <= 15'h0000;
      o_line <= 1'b1;
    end else if (i_clk_en) begin
      if (!busy) begin
        if (i_valid) begin
          busy <= 1'b1;
          o_line <= 1'b0;
          shift <= {1'b1, i_data};
          bits_left <= 4'h9;
          cycle <= 15'h0000;
        end
      end else if (cycle == BIT_CYCLES - 15'h0001) begin
        cycle <= 15'h0000;
        if (bits_left == 4'h0) begin
          busy <= 1'b0;
        end else begin
          o_line <= shift[0];
          shift <= {1'b1, shift[8:1]};
          bits_left <= bits_left - 4'h1;
        end
      end else begin
        cycle <= cycle + 15'h0001;
      end
    end
  end

endmodule // serial_tx

// >>> serial_console.v
// Notes on behaviour
// - fixed 9600 baud, no rate control
// - one transmit output, one receive input
// - carriage return alone ends a command
// - every reply line ends with carriage return
// - version line sent before any command
// - only query, read and write forms
// - lone query lists all 29 registers
// - number query replies number colon value
// - write stores value, then confirms it
// - number above 28 gives error, no change
// - malformed line gives command error
// - ignore all but digits, query, equals, return, backspace, delete
// - backspace drops last accepted character
// - strap at reset selects mode, held
// - each register is 32 bits unsigned
// - accepted value goes to nonvolatile store
`timescale 1ns/1ns
`include "console_defines.vh"

module serial_console #(
  parameter [14:0] BIT_CYCLES = `CON_BIT_CYCLES
) (
  // clock, reset, enable
  input wire i_clock,
  input wire i_rst_b,
  input wire i_clk_en,
  // serial pins
  input wire i_rxd,
  output wire o_txd,
  // mode strap
  input wire i_serial_strap,
  output reg o_serial_mode,
  // nonvolatile store write port
  output reg o_nv_write,
  output reg [4:0] o_nv_index,
  output reg [31:0] o_nv_data
);

  // ----------------------------------------
  // states and text
  // ----------------------------------------
  localparam [11:0] S_BOOT = 12'h001, S_OFF = 12'h002, S_IDLE = 12'h004, S_PARSE = 12'h008;
  localparam [11:0] S_MSG = 12'h010, S_CONV = 12'h020, S_TENS = 12'h040, S_ONES = 12'h080;
  localparam [11:0] S_COLON = 12'h100, S_DIG = 12'h200, S_COMMA = 12'h400, S_CR = 12'h800;
  localparam [3:0] RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8;
  localparam [3:0] PH_NUM = 4'h1, PH_QRY = 4'h2, PH_VAL = 4'h4, PH_BAD = 4'h8;
  // version text is arbitrary
  localparam [95:0] TXT_BANNER = "Console v0.1";
  localparam [95:0] TXT_CMD = {"Error: Cmd", 16'h0000};
  localparam [95:0] TXT_REG = {"Error: Reg", 16'h0000};

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [7:0] msg_char;
    input [1:0] sel;
    input [3:0] pos;
    reg [95:0] txt;
    begin
      txt = (sel == `CON_MSG_BANNER) ? TXT_BANNER :
            (sel == `CON_MSG_CMD_ERR) ? TXT_CMD : TXT_REG;
      msg_char = (pos > 4'hb) ? 8'h00 : txt[95 - 8 * pos -: 8];
    end
  endfunction

  // accepted symbol: bit 4 valid, low bits digit or query/equals code
  function [4:0] sym_of;
    input [7:0] c;
    begin
      if (c >= `CON_CHAR_ZERO && c <= `CON_CHAR_NINE) begin
        sym_of = {1'b1, c[3:0]};
      end else if (c == `CON_CHAR_QUERY) begin
        sym_of = {1'b1, `CON_SYM_QUERY};
      end else if (c == `CON_CHAR_EQUAL) begin
        sym_of = {1'b1, `CON_SYM_EQUAL};
      end else begin
        sym_of = 5'h00;
      end
    end
  endfunction

  // acc * 10 + d, upper bits flag overflow
  function [35:0] mul10_add;
    input [31:0] acc;
    input [3:0] d;
    begin
      mul10_add = ({4'h0, acc} << 3) + ({4'h0, acc} << 1) + {32'h00000000, d};
    end
  endfunction

  // one double-dabble step over 10 bcd digits and 32 binary bits
  function [71:0] dd_step;
    input [71:0] x;
    reg [71:0] y;
    integer k;
    begin
      y = x;
      for (k = 0; k < 10; k = k + 1) begin
        if (y[32 + 4 * k +: 4] > 4'h4) begin
          y[32 + 4 * k +: 4] = y[32 + 4 * k +: 4] + 4'h3;
        end
      end
      dd_step = {y[70:0], 1'b0};
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers and boot
  // ----------------------------------------
  reg rxd_s1, rxd_s2, strap_s1, strap_s2;
  reg [1:0] boot_cnt;

  // two flops on each pin before use
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      boot_cnt <= 2'h0;
    end else if (i_clk_en) begin
      rxd_s1 <= i_rxd;
      rxd_s2 <= rxd_s1;
      strap_s1 <= i_serial_strap;
      strap_s2 <= strap_s1;
      if (boot_cnt != `CON_BOOT_WAIT) boot_cnt <= boot_cnt + 2'h1;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  reg [3:0] rx_state;
  reg [14:0] rx_cnt;
  reg [2:0] rx_bit;
  reg [7:0] rx_sh, rx_byte;
  reg rx_strobe;

  // samples mid-bit, drops frames with a bad start or stop
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_state <= RX_IDLE;
      rx_cnt <= 15'h0000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_byte <= 8'h00;
      rx_strobe <= 1'b0;
    end else if (i_clk_en) begin
      rx_strobe <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_cnt <= 15'h0000;
          if (!rxd_s2) rx_state <= RX_START;
        end
        RX_START: begin
          if (rx_cnt == (BIT_CYCLES >> 1)) begin
            rx_cnt <= 15'h0000;
            rx_bit <= 3'h0;
            rx_state <= rxd_s2 ? RX_IDLE : RX_DATA;
          end else begin
            rx_cnt <= rx_cnt + 15'h0001;
          end
        end
        RX_DATA: begin
          if (rx_cnt == BIT_CYCLES - 15'h0001) begin
            rx_cnt <= 15'h0000;
            rx_sh <= {rxd_s2, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_state <= RX_STOP;
          end else begin
            rx_cnt <= rx_cnt + 15'h0001;
          end
        end
        RX_STOP: begin
          if (rx_cnt == BIT_CYCLES - 15'h0001) begin
            rx_strobe <= rxd_s2;
            rx_byte <= rx_sh;
            rx_state <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt + 15'h0001;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // interpreter state
  // ----------------------------------------
  reg [11:0] state;
  reg [31:0] cfg [0:`CON_REG_COUNT - 1];
  reg [3:0] line_buf [0:31];
  reg [5:0] cnt, p_idx;
  reg [3:0] ph, dpos, msg_pos;
  reg [31:0] acc_reg, acc_val;
  reg rov, vov, have_reg, have_val;
  reg [1:0] msg_sel;
  reg banner_done, list_mode, started;
  reg [4:0] cur_idx;
  reg [5:0] conv_cnt;
  reg [71:0] conv;
  reg tx_valid;
  reg [7:0] tx_byte;
  wire tx_ready;
  wire tx_fire = tx_valid & tx_ready;
  wire [4:0] rx_sym = sym_of(rx_byte);
  wire [3:0] p_sym = line_buf[p_idx[4:0]];
  wire [35:0] reg_next = mul10_add(acc_reg, p_sym);
  wire [35:0] val_next = mul10_add(acc_val, p_sym);
  wire reg_ok = !rov && (acc_reg <= `CON_REG_LAST);
  wire [1:0] tens = (cur_idx >= 5'h14) ? 2'h2 : (cur_idx >= 5'h0a) ? 2'h1 : 2'h0;
  wire [4:0] ones = cur_idx - ({3'h0, tens} << 3) - ({3'h0, tens} << 1);
  wire [3:0] digit = conv[32 + 4 * dpos +: 4];
  wire [7:0] msg_ch = msg_char(msg_sel, msg_pos);
  integer i;

  // character offered to the transmitter
  always @* begin
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    case (state)
      S_MSG: begin
        tx_valid = (msg_ch != 8'h00);
        tx_byte = msg_ch;
      end
      S_TENS: begin
        tx_valid = (tens != 2'h0);
        tx_byte = `CON_CHAR_ZERO + {6'h00, tens};
      end
      S_ONES: begin
        tx_valid = 1'b1;
        tx_byte = `CON_CHAR_ZERO + {4'h0, ones[3:0]};
      end
      S_COLON: begin
        tx_valid = 1'b1;
        tx_byte = `CON_CHAR_COLON;
      end
      S_DIG: begin
        tx_valid = (digit != 4'h0) || started || (dpos == 4'h0);
        tx_byte = `CON_CHAR_ZERO + {4'h0, digit};
      end
      S_COMMA: begin
        tx_valid = 1'b1;
        tx_byte = `CON_CHAR_COMMA;
      end
      S_CR: begin
        tx_valid = 1'b1;
        tx_byte = `CON_CHAR_CR;
      end
      default: tx_valid = 1'b0;
    endcase
  end

  // line collection, parsing and reply sequencing
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= S_BOOT;
      for (i = 0; i < `CON_REG_COUNT; i = i + 1) cfg[i] <= `CON_REG_RESET;
      for (i = 0; i < 32; i = i + 1) line_buf[i] <= 4'h0;
      cnt <= 6'h00;
      p_idx <= 6'h00;
      ph <= PH_NUM;
      dpos <= 4'h0;
      msg_pos <= 4'h0;
      acc_reg <= 32'h00000000;
      acc_val <= 32'h00000000;
      rov <= 1'b0;
      vov <= 1'b0;
      have_reg <= 1'b0;
      have_val <= 1'b0;
      msg_sel <= `CON_MSG_BANNER;
      banner_done <= 1'b0;
      list_mode <= 1'b0;
      started <= 1'b0;
      cur_idx <= 5'h00;
      conv_cnt <= 6'h00;
      conv <= 72'h0;
      o_serial_mode <= 1'b0;
      o_nv_write <= 1'b0;
      o_nv_index <= 5'h00;
      o_nv_data <= 32'h00000000;
    end else if (i_clk_en) begin
      o_nv_write <= 1'b0;
      // gather the pending line; nothing is echoed back
      if (rx_strobe && banner_done && state != S_PARSE) begin
        if (rx_byte == `CON_CHAR_CR) begin
          if (state == S_IDLE) begin
            state <= S_PARSE;
            p_idx <= 6'h00;
            ph <= PH_NUM;
            acc_reg <= 32'h00000000;
            acc_val <= 32'h00000000;
            rov <= 1'b0;
            vov <= 1'b0;
            have_reg <= 1'b0;
            have_val <= 1'b0;
          end
        end else if (rx_byte == `CON_CHAR_BS || rx_byte == `CON_CHAR_DEL) begin
          if (cnt != 6'h00) cnt <= cnt - 6'h01;
        end else if (rx_sym[4] && cnt != `CON_CNT_MAX) begin
          if (cnt < `CON_BUF_DEPTH) line_buf[cnt[4:0]] <= rx_sym[3:0];
          cnt <= cnt + 6'h01;
        end
      end
      case (state)
        S_BOOT: begin
          if (boot_cnt == `CON_BOOT_WAIT) begin
            o_serial_mode <= strap_s2;
            state <= strap_s2 ? S_MSG : S_OFF;
            msg_sel <= `CON_MSG_BANNER;
            msg_pos <= 4'h0;
          end
        end
        S_OFF: state <= S_OFF;
        // the gather logic above moves on to parsing; keep its state change
        S_IDLE: begin
        end
        S_PARSE: begin
          if (cnt > `CON_BUF_DEPTH) begin
            cnt <= 6'h00;
            msg_sel <= `CON_MSG_CMD_ERR;
            msg_pos <= 4'h0;
            state <= S_MSG;
          end else if (p_idx != cnt) begin
            p_idx <= p_idx + 6'h01;
            if (p_sym == `CON_SYM_QUERY) begin
              ph <= (ph == PH_NUM) ? PH_QRY : PH_BAD;
            end else if (p_sym == `CON_SYM_EQUAL) begin
              ph <= (ph == PH_NUM && have_reg) ? PH_VAL : PH_BAD;
            end else if (ph == PH_NUM) begin
              acc_reg <= reg_next[31:0];
              rov <= rov | (reg_next[35:32] != 4'h0);
              have_reg <= 1'b1;
            end else if (ph == PH_VAL) begin
              acc_val <= val_next[31:0];
              vov <= vov | (val_next[35:32] != 4'h0);
              have_val <= 1'b1;
            end else begin
              ph <= PH_BAD;
            end
          end else begin
            cnt <= 6'h00;
            conv_cnt <= 6'h00;
            msg_pos <= 4'h0;
            if (ph == PH_QRY && !have_reg) begin
              list_mode <= 1'b1;
              cur_idx <= 5'h00;
              state <= S_CONV;
            end else if (ph == PH_QRY || (ph == PH_VAL && have_val && !vov)) begin
              if (!reg_ok) begin
                msg_sel <= `CON_MSG_REG_ERR;
                state <= S_MSG;
              end else begin
                cur_idx <= acc_reg[4:0];
                state <= S_CONV;
                if (ph == PH_VAL) begin
                  cfg[acc_reg[4:0]] <= acc_val;
                  o_nv_write <= 1'b1;
                  o_nv_index <= acc_reg[4:0];
                  o_nv_data <= acc_val;
                end
              end
            end else begin
              msg_sel <= `CON_MSG_CMD_ERR;
              state <= S_MSG;
            end
          end
        end
        S_MSG: begin
          if (msg_ch == 8'h00) state <= S_CR;
          else if (tx_fire) msg_pos <= msg_pos + 4'h1;
        end
        S_CONV: begin
          conv_cnt <= conv_cnt + 6'h01;
          if (conv_cnt == 6'h00) conv <= {40'h0, cfg[cur_idx]};
          else conv <= dd_step(conv);
          if (conv_cnt == 6'h20) state <= S_TENS;
        end
        S_TENS: if (!tx_valid || tx_fire) state <= S_ONES;
        S_ONES: if (tx_fire) state <= S_COLON;
        S_COLON: begin
          if (tx_fire) begin
            state <= S_DIG;
            dpos <= 4'h9;
            started <= 1'b0;
          end
        end
        S_DIG: begin
          if (!tx_valid) begin
            dpos <= dpos - 4'h1;
          end else if (tx_fire) begin
            started <= 1'b1;
            if (dpos == 4'h0) state <= S_CR;
            else if (dpos == 4'h9 || dpos == 4'h6 || dpos == 4'h3) state <= S_COMMA;
            else dpos <= dpos - 4'h1;
          end
        end
        S_COMMA: begin
          if (tx_fire) begin
            dpos <= dpos - 4'h1;
            state <= S_DIG;
          end
        end
        S_CR: begin
          if (tx_fire) begin
            banner_done <= 1'b1;
            conv_cnt <= 6'h00;
            if (list_mode && cur_idx != `CON_REG_LAST_IDX) begin
              cur_idx <= cur_idx + 5'h01;
              state <= S_CONV;
            end else begin
              list_mode <= 1'b0;
              state <= S_IDLE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  serial_tx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_tx (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_valid(tx_valid),
    .i_data(tx_byte),
    .o_ready(tx_ready),
    .o_line(o_txd)
  );

endmodule // serial_console

// >>> console_monitor.sv
`timescale 1ns/1ns

// ------
// serial console checker
// ------
module console_monitor #(
  parameter [14:0] BIT_CYCLES = 15'h0010
) (
  // clock, reset, enable
  input wire i_clock,
  input wire i_rst_b,
  input wire i_clk_en,
  // serial pins
  input wire i_rxd,
  input wire o_txd,
  // mode strap
  input wire i_serial_strap,
  input wire o_serial_mode,
  // nonvolatile store port
  input wire o_nv_write,
  input wire [4:0] o_nv_index,
  input wire [31:0] o_nv_data
);
  reg [3:0] cnt;
  reg [15:0] low_run;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // edges since reset, length of the current low run on the transmit line
  always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 4'h0;
      low_run <= 16'h0000;
    end else begin
      if (cnt != 4'hf) cnt <= cnt + 4'h1;
      low_run <= o_txd ? 16'h0000 : low_run + 16'h0001;
    end
  end

  // store port
  a_nv_pulse: assert property (o_nv_write |=> !o_nv_write)
    else $error("nv write pulse too long");
  a_nv_hold: assert property (!o_nv_write |-> $stable(o_nv_index) && $stable(o_nv_data))
    else $error("nv port moved without a write");
  a_nv_range: assert property (o_nv_write |-> o_nv_index <= 5'h1c)
    else $error("nv write to a missing register");
  a_nv_mode: assert property (o_nv_write |-> o_serial_mode)
    else $error("nv write outside serial mode");
  a_store_first: assert property (o_nv_write |-> o_txd ##1 o_txd)
    else $error("reply started before the store");
  // mode strap
  a_mode_held: assert property (o_serial_mode |=> o_serial_mode)
    else $error("serial mode dropped");
  a_mode_strap: assert property ($rose(o_serial_mode) |-> i_serial_strap)
    else $error("serial mode without strap");
  a_mode_early: assert property ($changed(o_serial_mode) |-> cnt < 4'h8)
    else $error("mode changed late after reset");
  a_tx_quiet: assert property (!o_serial_mode |-> o_txd)
    else $error("transmit active outside serial mode");
  // line framing
  a_bit_len: assert property ($rose(o_txd) |-> (low_run % BIT_CYCLES) == 16'h0000)
    else $error("low run not whole bits");
  a_low_max: assert property (!o_txd |-> low_run < 9 * BIT_CYCLES)
    else $error("stop bit missing");
endmodule // console_monitor

bind serial_console console_monitor #(.BIT_CYCLES(BIT_CYCLES)) console_monitor_i (
  .i_clock(i_clock),
  .i_rst_b(i_rst_b),
  .i_clk_en(i_clk_en),
  .i_rxd(i_rxd),
  .o_txd(o_txd),
  .i_serial_strap(i_serial_strap),
  .o_serial_mode(o_serial_mode),
  .o_nv_write(o_nv_write),
  .o_nv_index(o_nv_index),
  .o_nv_data(o_nv_data)
);

// >>> term_model.sv
`timescale 1ns/1ns

// ------
// terminal at the far end of the link
// ------
module term_model #(
  parameter int BC = 16
) (
  // clock
  input wire i_clock,
  // crossed serial lines
  input wire i_txd,
  output logic o_rxd
);
  logic [191:0] line;
  logic [191:0] rx_line;
  logic [7:0] b;
  event line_ev;

  // one character: start, eight bits lsb first, stop
  task automatic send_byte(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int j = 0; j < 10; j++) begin
      @(negedge i_clock);
      o_rxd = f[j];
      repeat (BC - 1) @(negedge i_clock);
    end
  endtask

  // typed text, one frame per character, edit characters sent as typed
  task automatic send_str(input string s);
    for (int k = 0; k < s.len(); k++) send_byte(s[k]);
  endtask

  // idle level of the line
  initial o_rxd = 1'b1;
  initial line = '0;

  // frame decoder on the device transmit line, lines end at carriage return
  initial forever begin
    @(negedge i_txd);
    repeat (BC / 2) @(posedge i_clock);
    if (i_txd !== 1'b0) continue;
    for (int i = 0; i < 8; i++) begin
      repeat (BC) @(posedge i_clock);
      b[i] = i_txd;
    end
    repeat (BC) @(posedge i_clock);
    if (i_txd !== 1'b1) b = 8'h23; // bad stop bit spoils the line
    if (b === 8'h0d) begin
      rx_line = line;
      line = '0;
      -> line_ev;
    end else begin
      line = {line[183:0], b};
    end
  end
endmodule // term_model

// >>> tb_top.sv
`timescale 1ns/1ns

`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end

// ------
// console testbench
// ------
module tb_top;
  localparam int BC = 10;
  localparam int LIMIT = 90000;
  logic i_clock, i_rst_b, i_clk_en, i_serial_strap;
  wire i_rxd, o_txd, o_serial_mode, o_nv_write;
  wire [4:0] o_nv_index;
  wire [31:0] o_nv_data;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int r;
  logic [31:0] v;
  logic [191:0] lq[$];
  logic [36:0] nq[$];
  logic [31:0] regs[29];
  logic [191:0] el;
  logic [36:0] en;
  string cr, bs, del;
  string bad[8] = '{"qwerty", "?4", "4", "4==5", "4=5?", "4=4294967296", "",
    "000000000000000000000000000000004?"};

  serial_console #(.BIT_CYCLES(15'(BC))) serial_console_i (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_clk_en(i_clk_en),
    .i_rxd(i_rxd),
    .o_txd(o_txd),
    .i_serial_strap(i_serial_strap),
    .o_serial_mode(o_serial_mode),
    .o_nv_write(o_nv_write),
    .o_nv_index(o_nv_index),
    .o_nv_data(o_nv_data)
  );
  term_model #(.BC(BC)) term_model_i (.i_clock(i_clock), .i_txd(o_txd), .o_rxd(i_rxd));

  // text to right-aligned character vector
  function automatic logic [191:0] pack(input string s);
    logic [191:0] p;
    p = '0;
    for (int i = 0; i < s.len(); i++) p = {p[183:0], s[i]};
    return p;
  endfunction

  // unsigned decimal with a comma between groups of three
  function automatic string commas(input logic [31:0] x);
    string d, t;
    d = $sformatf("%0d", x);
    t = "";
    for (int i = 0; i < d.len(); i++) begin
      t = {t, d.substr(i, i)};
      if (i < d.len() - 1 && (d.len() - 1 - i) % 3 == 0) t = {t, ","};
    end
    return t;
  endfunction

  task automatic expect_line(input string s);
    lq.push_back(pack(s));
  endtask

  // wait for the expected lines, then for the last stop bit
  task automatic wait_idle();
    int n;
    n = 0;
    while (lq.size() != 0 && n < 40000) begin
      @(posedge i_clock);
      n++;
    end
    repeat (2 * BC) @(posedge i_clock);
  endtask

  task automatic cmd(input string s);
    term_model_i.send_str({s, cr});
    wait_idle();
  endtask

  task automatic do_reset(input logic s);
    @(negedge i_clock);
    i_rst_b = 1'b0;
    i_serial_strap = s;
    repeat (3) @(negedge i_clock);
    i_rst_b = 1'b1;
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // clock
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  // received lines against the oldest note
  always @(term_model_i.line_ev) begin
    el = '1;
    if (lq.size() != 0) el = lq.pop_front();
    `CHK(term_model_i.rx_line, el)
  end

  // store writes against the oldest note, sampled where the outputs are settled
  always @(negedge i_clock) begin
    if (o_nv_write === 1'b1) begin
      en = '1;
      if (nq.size() != 0) en = nq.pop_front();
      `CHK({o_nv_index, o_nv_data}, en)
    end
  end

  // hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      report_and_stop();
    end
  end

  // main sequence
  initial begin
    i_rst_b = 1'b0;
    i_clk_en = 1'b1;
    i_serial_strap = 1'b1;
    cr = " ";
    cr[0] = 8'h0d;
    bs = " ";
    bs[0] = 8'h08;
    del = " ";
    del[0] = 8'h7f;
    void'($urandom(56));
    foreach (regs[i]) regs[i] = 32'h00000000;
    expect_line("Console v0.1");
    do_reset(1'b1);
    wait_idle();
    `CHK(o_serial_mode, 1'b1)
    @(negedge i_clock);
    i_serial_strap = 1'b0;
    expect_line("4:0");
    cmd({bs, "4?"});
    // writes with leading zero, junk, separators and a backspace
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 28 : (k == 1) ? 0 : $urandom % 29;
      v = (k == 0) ? 32'hffffffff : (k == 1) ? 32'h00000000 : $urandom;
      regs[r] = v;
      nq.push_back({r[4:0], v});
      expect_line($sformatf("%0d:%s", r, commas(v)));
      cmd({"0", $sformatf("%0d", r), "a?", bs, "=", commas(v), "x"});
    end
    regs[4] = 32'h00989680;
    nq.push_back({5'h04, 32'h00989680});
    expect_line("4:10,000,000");
    cmd({"As4f=10aeae000r.0r007", del});
    r = $urandom % 29;
    expect_line($sformatf("%0d:%s", r, commas(regs[r])));
    cmd($sformatf("%0d?", r));
    // register and command errors
    expect_line("Error: Reg");
    cmd("29?");
    expect_line("Error: Reg");
    cmd("123=5");
    for (int k = 0; k < 8; k++) begin
      expect_line("Error: Cmd");
      cmd(bad[k]);
    end
    // full listing in ascending order
    for (int i = 0; i < 29; i++) expect_line($sformatf("%0d:%s", i, commas(regs[i])));
    cmd("?");
    // no strap: inert until the next reset
    do_reset(1'b0);
    term_model_i.send_str({"?", cr});
    repeat (4 * BC) @(posedge i_clock);
    `CHK(o_serial_mode, 1'b0)
    // strap again: banner, registers back at zero
    expect_line("Console v0.1");
    do_reset(1'b1);
    wait_idle();
    expect_line("28:0");
    cmd("28?");
    `CHK(lq.size() + nq.size(), 0)
    report_and_stop();
  end
endmodule // tb_top
